// [ffms_params.svh]
/*
 * timing counts, thresholds and selector codes for the flyback supervisor.
 * assumes a 50 MHz clock; included by the run filter, oscillator and supervisor modules.
 */
`ifndef FFMS_PARAMS_SVH
`define FFMS_PARAMS_SVH

// =====================================================================
// clock and times
// =====================================================================
`define FFMS_CLK_HZ           50000000
`define FFMS_SOFT_MS          15
`define FFMS_RESTART_MS       150
`define FFMS_RESTART_FIRST_MS 1500
`define FFMS_SD_DELAY_MS      35
`define FFMS_BURST_FAST_US    500
`define FFMS_BURST_LOW_US     4000
`define FFMS_PROBE_US         1000
`define FFMS_MS_CYC(ms)       ((ms) * (`FFMS_CLK_HZ / 1000))
`define FFMS_US_CYC(us)       ((us) * (`FFMS_CLK_HZ / 1000000))

// =====================================================================
// frequencies in kHz
// =====================================================================
`define FFMS_F_MIN_KHZ        32
`define FFMS_F_MAX_KHZ        132
`define FFMS_JITTER_KHZ       5

// =====================================================================
// consecutive-cycle counts
// =====================================================================
`define FFMS_BROWN_IN_RUN     2
`define FFMS_BROWN_OUT_RUN    8
`define FFMS_LINE_OV_RUN      2
`define FFMS_OUT_OV_RUN       16
`define FFMS_FILT_RUN         4

// =====================================================================
// shutdown type codes (bypass capacitance class)
// =====================================================================
`define FFMS_BP_SMALL         2'h0
`define FFMS_BP_MID           2'h1
`define FFMS_BP_LARGE         2'h2

// =====================================================================
// current-limit and compensation fractions in eighths, burst entry level in error units
// =====================================================================
`define FFMS_PK_COMP_OFF      4'h4
`define FFMS_PK_COMP_ON       4'h5
`define FFMS_ILIM_FULL        4'h8
`define FFMS_ILIM_BURST       4'h2
`define FFMS_BURST_ENTRY      8'h50

`endif

// [ffms_pkg.sv]
/*
 * types for the flyback supervisor.
 * assumes ffms_params.svh is present in the same folder.
 */
package ffms_pkg;
  typedef enum logic [2:0] {
    FFMS_PROBE,
    FFMS_SOFT,
    FFMS_RUN,
    FFMS_RESTART,
    FFMS_LATCHED
  } ffms_state_t;
endpackage : ffms_pkg

// [ffms_run_filter.sv]
/*
 * consecutive-cycle run counter; fires when a condition has held for RUN
 * cycle strobes without interruption.
 * assumes cyc is a one-clock strobe per switching cycle.
 */
`timescale 1ns/1ns
`include "ffms_params.svh"
module ffms_run_filter
  import ffms_pkg::*;
#(
  parameter int RUN = 2
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // cycle strobe and condition
  input  wire logic cyc,
  input  wire logic cond,
  input  wire logic clr,
  // filtered result, level
  output logic      hit
);
  localparam int W = $clog2(RUN + 1);
  initial if (RUN < 1) $error("ffms_run_filter: RUN must be at least 1");

  logic [W-1:0] cnt_r;
  wire  [W-1:0] run_w = W'(RUN);
  wire          full_w = (cnt_r == run_w);

  // [RULE18] break clears count
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      cnt_r <= '0;
    else if (clr)
      cnt_r <= '0;
    else if (cyc)
      cnt_r <= !cond ? '0 : (full_w ? cnt_r : cnt_r + W'(1));

  assign hit = full_w;
endmodule : ffms_run_filter

// [ffms_osc.sv]
/*
 * variable-frequency switching oscillator with triangular jitter.
 * assumes err is the error level, 0 light load to 255 heavy load.
 */
`timescale 1ns/1ns
`include "ffms_params.svh"
module ffms_osc
  import ffms_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic       burst,
  input  wire logic [7:0] err,
  // one-clock pulse at each cycle start
  output logic            tick
);
  localparam int FMIN = `FFMS_F_MIN_KHZ;
  localparam int FSPAN = `FFMS_F_MAX_KHZ - `FFMS_F_MIN_KHZ;
  localparam int JIT = `FFMS_JITTER_KHZ;

  logic [15:0] cnt_r;
  logic [3:0]  jit_r;
  logic        jdir_r;
  logic [7:0]  fkhz_w;
  logic [15:0] period_w;

  // [RULE8] frequency follows error
  // [RULE11] burst trends to minimum
  assign fkhz_w = burst ? 8'(FMIN)
                        : 8'(FMIN + ((FSPAN * int'(err)) / 255) + int'(jit_r) - JIT);
  // [RULE9] plus or minus jitter
  assign period_w = 16'((`FFMS_CLK_HZ / 1000) / int'(fkhz_w));

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_r  <= 16'h0000;
      jit_r  <= 4'h5;
      jdir_r <= 1'b1;
    end
    else if (!run)
      cnt_r <= 16'h0000;
    else if (cnt_r + 16'h0001 >= period_w)
    begin
      cnt_r  <= 16'h0000;
      jdir_r <= (jit_r == 4'(2 * JIT - 1) && jdir_r) ? 1'b0 :
                (jit_r == 4'h1 && !jdir_r) ? 1'b1 : jdir_r;
      jit_r  <= jdir_r ? jit_r + 4'h1 : jit_r - 4'h1;
    end
    else
      cnt_r <= cnt_r + 16'h0001;

  assign tick = run && (cnt_r == 16'h0000);
endmodule : ffms_osc

// [ffms_supervisor.sv]
/*
 * flyback fault and mode supervisor: brown-in probing, soft-start,
 * line and output fault filtering, restart, latch-off, burst and
 * current-limit line compensation.
 * assumes comparator inputs are synchronous and valid at each cycle end.
 */
// Contract
// [RULE1] start after two brown-in cycles, soft-start
// [RULE2] stop after eight brown-out cycles
// [RULE3] brown-out stop enters 150 ms restart
// [RULE4] stop after two line-overvoltage cycles
// [RULE5] compensation off below half, on five-eighths
// [RULE6] reference ramps zero to full over 15 ms
// [RULE7] all fault inputs pass a digital filter
// [RULE8] frequency 32 to 132 kHz by error
// [RULE9] plus or minus 5 kHz jitter
// [RULE10] current limit ends the on-cycle
// [RULE11] burst entry: quarter limit, low frequency
// [RULE12] burst off-time bounded 0.5 or 4 ms
// [RULE13] low-rate probe pulses, clamp sense pin
// [RULE14] output overvoltage after sixteen cycles
// [RULE15] output low beyond shutdown delay faults
// [RULE16] shutdown type latched at power-up
// [RULE17] first restart off 1500 ms, then soft-start
// [RULE18] fault counters clear on broken runs
// [RULE19] latch needs reset, others self-clear
`timescale 1ns/1ns
`include "ffms_params.svh"
module ffms_supervisor
  import ffms_pkg::*;
#(
  parameter int SOFT_CYC    = `FFMS_MS_CYC(`FFMS_SOFT_MS),
  parameter int RESTART_CYC = `FFMS_MS_CYC(`FFMS_RESTART_MS),
  parameter int FIRST_CYC   = `FFMS_MS_CYC(`FFMS_RESTART_FIRST_MS),
  parameter int SD_CYC      = `FFMS_MS_CYC(`FFMS_SD_DELAY_MS),
  parameter int BFAST_CYC   = `FFMS_US_CYC(`FFMS_BURST_FAST_US),
  parameter int BLOW_CYC    = `FFMS_US_CYC(`FFMS_BURST_LOW_US),
  parameter int PROBE_CYC   = `FFMS_US_CYC(`FFMS_PROBE_US),
  parameter int REF_W       = 10
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // strap and variant
  input  wire logic [1:0]       bp_class,
  input  wire logic             fast_variant,
  input  wire logic             latch_reset,
  // line sense comparators, valid at cycle end
  input  wire logic             brown_in_current,
  input  wire logic             brown_out_current,
  input  wire logic             line_over_current_level,
  // output sense comparators
  input  wire logic             out_ov_cmp,
  input  wire logic             out_low_cmp,
  input  wire logic             sd_delay_ext,
  input  wire logic             thermal_hot,
  input  wire logic             pin_fault,
  // current and compensation
  input  wire logic             ilim_cmp,
  input  wire logic [3:0]       peak_eighths,
  input  wire logic [7:0]       err_level,
  // drive and status
  output logic                  switch_on,
  output logic                  sense_clamp,
  output logic                  line_comp_en,
  output logic                  burst_mode,
  output logic [3:0]            ilim_eighths,
  output logic [REF_W-1:0]      reg_ref,
  output logic                  line_low_fault,
  output logic                  line_high_fault,
  output logic                  output_over_voltage_fault,
  output logic                  output_over_load_fault,
  output logic                  latched_off
);
  initial if (REF_W < 4 || SOFT_CYC < 1 || SD_CYC < 1)
    $error("ffms_supervisor: parameter values out of range");

  // =====================================================================
  // state and counters
  // =====================================================================
  ffms_state_t state_r, state_nxt;
  logic [31:0] tmr_r;
  logic [31:0] low_r;
  logic [31:0] boff_r;
  logic        first_r;
  logic        strap_done_r;
  logic [1:0]  sd_type_r;
  logic        therm_r;
  logic        sw_r;
  logic        clamp_r;
  logic        comp_r;
  logic        burst_r;
  logic [REF_W-1:0] ref_r;
  logic        llf_r, lhf_r, ovf_r, olf_r;

  // =====================================================================
  // oscillator and cycle strobe
  // =====================================================================
  wire running_w = (state_r == FFMS_SOFT) || (state_r == FFMS_RUN);
  wire burst_gap_w;
  wire osc_tick;

  ffms_osc u_osc (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (running_w && !burst_gap_w),
    .burst (burst_r),
    .err   (err_level),
    .tick  (osc_tick)
  );

  wire probe_tick_w = (state_r == FFMS_PROBE) && (tmr_r == 32'(PROBE_CYC - 1));
  wire cyc_w        = osc_tick || probe_tick_w;

  // =====================================================================
  // fault filters
  // =====================================================================
  wire bin_hit, bout_hit, lov_hit, oov_hit, therm_hit, pin_hit;

  // [RULE1] brown-in run of two
  ffms_run_filter #(.RUN(`FFMS_BROWN_IN_RUN)) u_bin (
    .clk(clk), .rst_n(rst_n), .cyc(probe_tick_w), .cond(brown_in_current),
    .clr(state_r != FFMS_PROBE), .hit(bin_hit));
  // [RULE2] brown-out run of eight
  ffms_run_filter #(.RUN(`FFMS_BROWN_OUT_RUN)) u_bout (
    .clk(clk), .rst_n(rst_n), .cyc(osc_tick), .cond(brown_out_current),
    .clr(!running_w), .hit(bout_hit));
  // [RULE4] line overvoltage run of two
  ffms_run_filter #(.RUN(`FFMS_LINE_OV_RUN)) u_lov (
    .clk(clk), .rst_n(rst_n), .cyc(osc_tick), .cond(line_over_current_level),
    .clr(!running_w), .hit(lov_hit));
  // [RULE14] output overvoltage run of sixteen
  ffms_run_filter #(.RUN(`FFMS_OUT_OV_RUN)) u_oov (
    .clk(clk), .rst_n(rst_n), .cyc(osc_tick), .cond(out_ov_cmp),
    .clr(!running_w), .hit(oov_hit));
  // [RULE7] thermal and pin filters
  ffms_run_filter #(.RUN(`FFMS_FILT_RUN)) u_thm (
    .clk(clk), .rst_n(rst_n), .cyc(cyc_w), .cond(thermal_hot),
    .clr(1'b0), .hit(therm_hit));
  ffms_run_filter #(.RUN(`FFMS_FILT_RUN)) u_pin (
    .clk(clk), .rst_n(rst_n), .cyc(cyc_w), .cond(pin_fault),
    .clr(1'b0), .hit(pin_hit));

  // [RULE15] output low beyond delay
  wire low_trip_w = (low_r >= 32'(SD_CYC)) && !sd_delay_ext;

  // [RULE16] shutdown type decode
  wire ov_latch_w  = (sd_type_r == `FFMS_BP_SMALL) || (sd_type_r == `FFMS_BP_LARGE);
  wire ol_latch_w  = (sd_type_r == `FFMS_BP_LARGE);
  wire th_latch_w  = ov_latch_w;
  wire latch_evt_w = (oov_hit && ov_latch_w) || (low_trip_w && ol_latch_w)
                   || (therm_hit && th_latch_w) || pin_hit;
  wire restart_evt_w = bout_hit || lov_hit || oov_hit || low_trip_w;

  // [RULE12] burst off-interval bound
  wire [31:0] boff_max_w = fast_variant ? 32'(BFAST_CYC) : 32'(BLOW_CYC);
  assign burst_gap_w = burst_r && (err_level < `FFMS_BURST_ENTRY - 8'h10)
                       && (boff_r < boff_max_w);

  // =====================================================================
  // state machine
  // =====================================================================
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FFMS_PROBE:
        if (strap_done_r && bin_hit && !therm_r)
          state_nxt = FFMS_SOFT;
      FFMS_SOFT, FFMS_RUN:
        // [RULE19] latch or restart
        if (latch_evt_w)
          state_nxt = FFMS_LATCHED;
        // [RULE3] restart after stop
        else if (restart_evt_w || therm_hit)
          state_nxt = FFMS_RESTART;
        else if (state_r == FFMS_SOFT && tmr_r >= 32'(SOFT_CYC - 1))
          state_nxt = FFMS_RUN;
      FFMS_RESTART:
        // [RULE17] first off-period longer
        if (tmr_r >= (first_r ? 32'(FIRST_CYC - 1) : 32'(RESTART_CYC - 1))
            && !therm_hit)
          state_nxt = FFMS_SOFT;
      FFMS_LATCHED:
        // [RULE19] external latch reset
        if (latch_reset)
          state_nxt = FFMS_PROBE;
      default:
        state_nxt = FFMS_PROBE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      state_r <= FFMS_PROBE;
    else
      state_r <= state_nxt;

  wire enter_w = (state_nxt != state_r);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      tmr_r <= 32'h0000_0000;
    else if (enter_w || probe_tick_w)
      tmr_r <= 32'h0000_0000;
    else
      tmr_r <= tmr_r + 32'h0000_0001;

  // [RULE16] strap caught after release
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      strap_done_r <= 1'b0;
      sd_type_r    <= `FFMS_BP_MID;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      sd_type_r    <= bp_class;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      first_r <= 1'b1;
    else if (state_r == FFMS_RESTART && enter_w)
      first_r <= 1'b0;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      therm_r <= 1'b0;
    else
      therm_r <= therm_hit;

  // [RULE15] shutdown delay count
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      low_r <= 32'h0000_0000;
    else if (state_r != FFMS_RUN || !out_low_cmp)
      low_r <= 32'h0000_0000;
    else if (!low_trip_w)
      low_r <= low_r + 32'h0000_0001;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      boff_r <= 32'h0000_0000;
    else if (osc_tick || !burst_r)
      boff_r <= 32'h0000_0000;
    else
      boff_r <= boff_r + 32'h0000_0001;

  // =====================================================================
  // switch drive, clamp, reference and modes
  // =====================================================================
  // [RULE10] current limit ends on-time
  // [RULE13] probe pulse with clamp
  wire go_w      = (state_nxt == FFMS_SOFT) || (state_nxt == FFMS_RUN);
  wire sw_nxt    = ((running_w && go_w && osc_tick) || probe_tick_w) ? 1'b1
                 : (ilim_cmp || !go_w && !clamp_r) ? 1'b0 : sw_r;
  wire clamp_nxt = probe_tick_w ? 1'b1 : (ilim_cmp ? 1'b0 : clamp_r);
  // [RULE5] compensation hysteresis
  wire comp_nxt  = (peak_eighths < `FFMS_PK_COMP_OFF) ? 1'b0
                 : (peak_eighths >= `FFMS_PK_COMP_ON) ? 1'b1 : comp_r;
  // [RULE11] burst entry level
  wire burst_nxt = running_w && (err_level <= `FFMS_BURST_ENTRY);
  // [RULE6] soft-start reference ramp
  wire [REF_W-1:0] ref_nxt =
      (state_r == FFMS_RUN) ? {REF_W{1'b1}}
    : (state_r == FFMS_SOFT) ? REF_W'((64'(tmr_r) * ((64'd1 << REF_W) - 1)) / 64'(SOFT_CYC))
    : '0;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      sw_r    <= 1'b0;
      clamp_r <= 1'b0;
      comp_r  <= 1'b1;
      burst_r <= 1'b0;
      ref_r   <= '0;
    end
    else
    begin
      sw_r    <= sw_nxt;
      clamp_r <= clamp_nxt;
      comp_r  <= comp_nxt;
      burst_r <= burst_nxt;
      ref_r   <= ref_nxt;
    end

  // sticky fault flags, cleared once the state machine is back in probe
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      llf_r <= 1'b0;
      lhf_r <= 1'b0;
      ovf_r <= 1'b0;
      olf_r <= 1'b0;
    end
    else
    begin
      llf_r <= bout_hit || (llf_r && state_r != FFMS_PROBE);
      lhf_r <= lov_hit || (lhf_r && state_r != FFMS_PROBE);
      ovf_r <= oov_hit || (ovf_r && state_r != FFMS_PROBE);
      olf_r <= low_trip_w || (olf_r && state_r != FFMS_PROBE);
    end

  // =====================================================================
  // outputs
  // =====================================================================
  logic [3:0] ilim_r;
  logic       latched_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ilim_r    <= `FFMS_ILIM_FULL;
      latched_r <= 1'b0;
    end
    else
    begin
      ilim_r    <= burst_nxt ? `FFMS_ILIM_BURST : `FFMS_ILIM_FULL;
      latched_r <= (state_nxt == FFMS_LATCHED);
    end

  assign switch_on                 = sw_r;
  assign sense_clamp               = clamp_r;
  assign line_comp_en              = comp_r;
  assign burst_mode                = burst_r;
  assign ilim_eighths              = ilim_r;
  assign reg_ref                   = ref_r;
  assign line_low_fault            = llf_r;
  assign line_high_fault           = lhf_r;
  assign output_over_voltage_fault = ovf_r;
  assign output_over_load_fault    = olf_r;
  assign latched_off               = latched_r;
endmodule : ffms_supervisor

// [ffms_stage_model.sv]
/* behavioural power stage: trips the current comparator after an on-time.
   assumes switch_on is registered on clk by the supervisor. */
`timescale 1ns/1ns
module ffms_stage_model #(
  parameter int ON_CYC = 6
)
(
  // clock
  input  wire logic clk,
  // switch drive and slow-ramp select
  input  wire logic switch_on,
  input  wire logic slow,
  // current comparator
  output logic      ilim_cmp
);
  int on_cnt = 0;
  initial ilim_cmp = 1'b0;
  // ramp length picks a prompt or a slow answer
  always @(posedge clk)
  begin
    #2;
    on_cnt = switch_on ? on_cnt + 1 : 0;
    ilim_cmp = switch_on && (on_cnt >= (slow ? 4 * ON_CYC : ON_CYC));
  end
endmodule : ffms_stage_model

// [ffms_monitor.sv]
/* assertions on the supervisor ports.
   assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ns
module ffms_monitor
  import ffms_pkg::*;
#(
  parameter int REF_W = 10
)
(
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  // inputs
  input wire logic             brown_in_current,
  input wire logic             out_ov_cmp,
  input wire logic             ilim_cmp,
  input wire logic [3:0]       peak_eighths,
  // outputs
  input wire logic             switch_on,
  input wire logic             sense_clamp,
  input wire logic             line_comp_en,
  input wire logic             burst_mode,
  input wire logic [3:0]       ilim_eighths,
  input wire logic [REF_W-1:0] reg_ref,
  input wire logic             line_high_fault,
  input wire logic             output_over_voltage_fault,
  input wire logic             latched_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // =====================================================
  // run counters of switching pulses
  // =====================================================
  logic [4:0] ov_run_r;
  logic [1:0] bi_run_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ov_run_r <= 5'h00;
      bi_run_r <= 2'h0;
    end
    else
    begin
      ov_run_r <= !out_ov_cmp ? 5'h00 :
                  ($rose(switch_on) && ov_run_r != 5'h1F) ? ov_run_r + 5'h01 : ov_run_r;
      bi_run_r <= !brown_in_current ? 2'h0 :
                  ($rose(sense_clamp) && bi_run_r != 2'h3) ? bi_run_r + 2'h1 : bi_run_r;
    end
  end
  // =====================================================
  // assertions
  // =====================================================
  a_reset_values: assert property (disable iff (1'b0)
    !rst_n |-> line_comp_en && ilim_eighths == 4'h8 && !switch_on)
    else $error("wrong output during reset");
  a_ilim_ends_on: assert property (switch_on && ilim_cmp |=> !switch_on)
    else $error("on-time not ended by current limit");
  a_burst_limit: assert property (ilim_eighths == (burst_mode ? 4'h2 : 4'h8))
    else $error("current limit does not follow burst");
  a_comp_on_level: assert property ($rose(line_comp_en) |-> $past(peak_eighths) >= 4'h5)
    else $error("compensation on below five eighths");
  a_comp_off_level: assert property ($fell(line_comp_en) |-> $past(peak_eighths) < 4'h4)
    else $error("compensation off above half");
  a_latch_quiet: assert property (latched_off |-> !switch_on)
    else $error("switching while latched");
  a_line_ov_stop: assert property (
    $rose(line_high_fault) |-> !switch_on [*8])
    else $error("switching after line overvoltage");
  a_ovp_run_len: assert property ($rose(output_over_voltage_fault) |-> ov_run_r >= 5'h0F)
    else $error("overvoltage flagged on a short run");
  a_start_probed: assert property (
    reg_ref != '0 && $past(reg_ref) == '0 |-> bi_run_r != 2'h0)
    else $error("start without brown-in probing");
  a_clamp_pulse: assert property (sense_clamp |-> switch_on)
    else $error("clamp outside a pulse");
endmodule : ffms_monitor
bind ffms_supervisor ffms_monitor #(.REF_W(REF_W)) ffms_monitor_i (.clk, .rst_n,
  .brown_in_current, .out_ov_cmp, .ilim_cmp, .peak_eighths, .switch_on, .sense_clamp,
  .line_comp_en, .burst_mode, .ilim_eighths, .reg_ref, .line_high_fault,
  .output_over_voltage_fault, .latched_off);

// [testbench.sv]
/* self-checking bench for the supervisor with a behavioural power stage.
   assumes shortened counts; strap class 0, then class 2 after a mid-run reset. */
`timescale 1ns/1ns
module testbench
  import ffms_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b1, fast_variant = 1'b1, latch_reset = 1'b0;
  logic [1:0] bp_class = 2'h0;
  logic sd_delay_ext = 1'b0, thermal_hot = 1'b0, pin_fault = 1'b0;
  localparam int SOFT_T = 200, RESTART_T = 300, FIRST_T = 600, SD_T = 400;
  localparam int BFAST_T = 1000, BLOW_T = 1500, PROBE_T = 100;
  logic brown_in_current = 1'b0, brown_out_current = 1'b0, line_over_current_level = 1'b0;
  logic out_ov_cmp = 1'b0, out_low_cmp = 1'b0, ilim_cmp, slow = 1'b0;
  logic [3:0] peak_eighths = 4'h8, ilim_eighths;
  logic [7:0] err_level = 8'hFF;
  logic switch_on, sense_clamp, line_comp_en, burst_mode, line_low_fault, line_high_fault;
  logic output_over_voltage_fault, output_over_load_fault, latched_off, sw_d = 1'b0;
  logic [9:0] reg_ref;
  int err_count = 0, comparisons = 0, rises = 0, snap, mn, mx, gap;
  typedef struct {logic [3:0] pk; logic [7:0] er; logic cm; logic bu; logic [3:0] il;} ffms_row_t;
  ffms_row_t rows [7] = '{'{4'h3, 8'hFF, 1'b0, 1'b0, 4'h8}, '{4'h4, 8'hFF, 1'b0, 1'b0, 4'h8},
    '{4'h5, 8'hFF, 1'b1, 1'b0, 4'h8}, '{4'h4, 8'hFF, 1'b1, 1'b0, 4'h8},
    '{4'h3, 8'h40, 1'b0, 1'b1, 4'h2}, '{4'h4, 8'h50, 1'b0, 1'b1, 4'h2},
    '{4'h5, 8'h51, 1'b1, 1'b0, 4'h8}};
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    sw_d <= switch_on;
    if (switch_on && !sw_d) rises++;
  end
  ffms_supervisor #(.SOFT_CYC(SOFT_T), .RESTART_CYC(RESTART_T), .FIRST_CYC(FIRST_T),
    .SD_CYC(SD_T), .BFAST_CYC(BFAST_T), .BLOW_CYC(BLOW_T), .PROBE_CYC(PROBE_T))
    ffms_supervisor_i (.clk, .rst_n, .bp_class, .fast_variant, .latch_reset, .brown_in_current,
    .brown_out_current, .line_over_current_level, .out_ov_cmp, .out_low_cmp, .sd_delay_ext,
    .thermal_hot, .pin_fault, .ilim_cmp, .peak_eighths, .err_level, .switch_on,
    .sense_clamp, .line_comp_en, .burst_mode, .ilim_eighths, .reg_ref, .line_low_fault,
    .line_high_fault, .output_over_voltage_fault, .output_over_load_fault, .latched_off);
  ffms_stage_model ffms_stage_model_i (.clk, .switch_on, .slow, .ilim_cmp);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int i;
    i = 0;
    while (s !== v && i < lim)
    begin
      cyc(1);
      i++;
    end
    chk(s === v, "wait timed out");
  endtask : wait_lvl
  // period min and max between pulse starts, longest off gap
  task automatic measure(input int n);
    int c, off, k;
    logic p;
    mn = 99999; mx = 0; gap = 0; c = -1; off = 0; k = 0; p = switch_on;
    while (k < n)
    begin
      cyc(1);
      off = switch_on ? 0 : off + 1;
      gap = (off > gap) ? off : gap;
      c = (c >= 0) ? c + 1 : c;
      if (switch_on && !p)
      begin
        if (c > 0) mn = (c < mn) ? c : mn;
        if (c > 0) mx = (c > mx) ? c : mx;
        c = 0;
        k++;
      end
      p = switch_on;
    end
  endtask : measure
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial
  begin
    #1600000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    #2 rst_n = 1'b0;
    cyc(12);
    chk(switch_on === 1'b0 && line_comp_en === 1'b1 && reg_ref === 10'h000, "reset");
    rst_n = 1'b1;
    wait_lvl(sense_clamp, 1'b1, 300);
    cyc(300);
    chk(reg_ref === 10'h000, "started without brown-in");
    wait_lvl(sense_clamp, 1'b1, 300);
    brown_in_current = 1'b1;
    cyc(100);
    brown_in_current = 1'b0;
    cyc(300);
    chk(reg_ref === 10'h000, "started on one probe");
    brown_in_current = 1'b1;
    slow = 1'b1;
    cyc(700);
    slow = 1'b0;
    chk(reg_ref === 10'h3FF, "reference not full");
    for (int r = 0; r < 7; r++)
    begin
      peak_eighths = rows[r].pk;
      err_level = rows[r].er;
      cyc(2000);
      chk(line_comp_en === rows[r].cm, "compensation");
      chk(burst_mode === rows[r].bu && ilim_eighths === rows[r].il, "burst");
    end
    err_level = 8'hFF;
    measure(20);
    chk(mn >= 364 && mx <= 393, "heavy-load period");
    err_level = 8'h00;
    measure(8);
    chk(gap <= 1002, "fast burst gap");
    fast_variant = 1'b0;
    measure(8);
    chk(gap <= 1502, "low burst gap");
    err_level = 8'hFF;
    cyc(1000);
    brown_out_current = 1'b1;
    cyc(2190);
    chk(line_low_fault === 1'b0, "brown-out too early");
    wait_lvl(line_low_fault, 1'b1, 2500);
    brown_out_current = 1'b0;
    cyc(2);
    snap = rises;
    cyc(560);
    chk(rises === snap, "switching in first restart");
    cyc(400);
    chk(rises > snap, "no switching after restart");
    cyc(800);
    line_over_current_level = 1'b1;
    wait_lvl(line_high_fault, 1'b1, 1500);
    line_over_current_level = 1'b0;
    cyc(2);
    snap = rises;
    cyc(260);
    chk(rises === snap, "switching in restart");
    cyc(440);
    chk(rises > snap, "no switching after restart");
    cyc(800);
    out_ov_cmp = 1'b1;
    wait_lvl(latched_off, 1'b1, 9000);
    chk(output_over_voltage_fault === 1'b1, "overvoltage flag");
    out_ov_cmp = 1'b0;
    snap = rises;
    cyc(1000);
    chk(rises === snap && latched_off === 1'b1, "latch released");
    latch_reset = 1'b1;
    cyc(2);
    latch_reset = 1'b0;
    cyc(3);
    chk(latched_off === 1'b0 && output_over_voltage_fault === 1'b0, "latch reset");
    cyc(1000);
    out_low_cmp = 1'b1;
    cyc(350);
    chk(output_over_load_fault === 1'b0, "overload too early");
    wait_lvl(output_over_load_fault, 1'b1, 2000);
    out_low_cmp = 1'b0;
    cyc(2);
    chk(latched_off === 1'b0, "overload latched in class 0");
    pin_fault = 1'b1;
    wait_lvl(latched_off, 1'b1, 3000);
    pin_fault = 1'b0;
    rst_n = 1'b0;
    bp_class = 2'h2;
    cyc(2);
    rst_n = 1'b1;
    cyc(600);
    sd_delay_ext = 1'b1;
    out_low_cmp = 1'b1;
    cyc(800);
    chk(output_over_load_fault === 1'b0, "delay extension ignored");
    sd_delay_ext = 1'b0;
    wait_lvl(latched_off, 1'b1, 20);
    out_low_cmp = 1'b0;
    thermal_hot = 1'b1;
    latch_reset = 1'b1;
    cyc(2);
    latch_reset = 1'b0;
    wait_lvl(latched_off, 1'b1, 2000);
    give_verdict();
  end
endmodule : testbench
